// >>> rtl/sisc_top.sv
// socket interrupt and general control with card status change detection
// assumes an indexed register port on the host clock, pins asynchronous
//
// Function
// - irq codes: off, lines, way-only codes
// - card irq signalled only in serial mode
// - irq selection applies only in io mode
// - io bit selects memory or io pin use
// - reset bit drives socket reset, ata-aware polarity
// - output enable low floats the reset pin
// - io mode: ring enable passes ring pin to pme
// - registers kept on retained soft reset
// - memory mode: status pin fall sets flag
// - io mode: either status pin edge sets
// - memory mode: warning pin fall sets flag
// - memory mode: ready pin transition sets ready flag
// - either card-detect change sets flag
// - status read returns flags then clears
// - upper four status bits read zero
// - flags identify the management interrupt source
// - management interrupt needs per-source enable
`timescale 1ns/100ps
`default_nettype none

module sisc_top (
    input  wire logic       core_clk,             // host clock, 10 MHz
    input  wire logic       rst_n,                // async reset, active low
    // register port
    input  wire logic [7:0] regIndex,             // register index
    input  wire logic       regWrite,             // write strobe, one cycle
    input  wire logic       regRead,              // read strobe, one cycle
    input  wire logic [7:0] regWdata,             // write data
    output logic      [7:0] regRdata,             // read data
    output logic            regRvalid,            // read data valid pulse
    // power management context
    input  wire logic       softSegmentReset,     // soft bus segment reset pulse
    input  wire logic       powerContextRetained, // pme enable true, keep context
    // host-side mode straps
    input  wire logic       serialIrqMode,        // 1 serial, 0 pci signalling
    input  wire logic       wayMode,              // serial way mode
    input  wire logic       ataMode,              // socket in ata mode
    input  wire logic       socketOutputEnable,   // socket outputs enabled
    // socket pins
    input  wire logic       cardReadyIrqPin,      // ready / irq request, low = irq
    input  wire logic       batteryStatusRingPin, // battery / status / ring
    input  wire logic       batteryWarnSpeakerPin,// battery warning
    input  wire logic       cardDetectOnePin,     // card detect one, active low
    input  wire logic       cardDetectTwoPin,     // card detect two, active low
    output logic            cardResetOut,         // card reset level
    output logic            cardResetOe,          // card reset drive enable
    output logic            ioInterfaceMode,      // dual-function pins in io use
    // interrupts and events
    output logic            cardIrqReq,           // card irq asserted
    output logic      [3:0] cardIrqLine,          // selected irq code
    output logic            systemMgmtInterrupt,  // management interrupt, high
    output logic            powerEventOutputN     // power event, active low
);

    sisc_pin_if pins ();

    sisc_pin_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinRaw   ({cardDetectTwoPin, cardDetectOnePin, batteryWarnSpeakerPin,
                    batteryStatusRingPin, cardReadyIrqPin}),
        .pins     (pins.sync)
    );

    sisc_pkg::sisc_top_s stQ;
    sisc_pkg::sisc_top_s stD;

    // codes valid in every serial mode, or only in way mode
    function automatic logic irqCodeUsable(input logic [3:0] code, input logic way);
        logic wayOnly;
        wayOnly = (code == sisc_pkg::IRQ_WAY_1) || (code == sisc_pkg::IRQ_WAY_2) ||
                  (code == sisc_pkg::IRQ_WAY_6) || (code == sisc_pkg::IRQ_WAY_8) ||
                  (code == sisc_pkg::IRQ_WAY_13);
        if (code == sisc_pkg::IRQ_OFF) begin
            irqCodeUsable = 1'b0;
        end else if (wayOnly) begin
            irqCodeUsable = way;
        end else begin
            irqCodeUsable = 1'b1;
        end
    endfunction : irqCodeUsable

    logic                           ioMode;
    logic                           ringEn;
    logic                           resetBit;
    logic [3:0]                     irqSel;
    logic [sisc_pkg::NUM_FLAGS-1:0] setFlags;
    logic [sisc_pkg::NUM_FLAGS-1:0] keptFlags;
    logic                           resetActive;
    logic                           clearCtx;
    logic                           readFlags;

    always_comb begin
        stD       = stQ;
        ioMode    = stQ.ctrl[sisc_pkg::CTRL_IO_BIT];
        ringEn    = stQ.ctrl[sisc_pkg::CTRL_RING_BIT];
        resetBit  = stQ.ctrl[sisc_pkg::CTRL_RST_BIT];
        irqSel    = stQ.ctrl[sisc_pkg::CTRL_IRQ_MSB:sisc_pkg::CTRL_IRQ_LSB];
        clearCtx  = softSegmentReset && !powerContextRetained;
        readFlags = regRead && (regIndex == sisc_pkg::REG_FLAGS_IDX);

        // change detection
        setFlags = '0;
        if (ioMode) begin
            // either edge, regardless of ring enable
            setFlags[sisc_pkg::FLAG_BSR] = pins.rise[sisc_pkg::PIN_BSR] |
                                           pins.fall[sisc_pkg::PIN_BSR];
        end else begin
            setFlags[sisc_pkg::FLAG_BSR] = pins.fall[sisc_pkg::PIN_BSR];
            setFlags[sisc_pkg::FLAG_BW]  = pins.fall[sisc_pkg::PIN_BW];
            setFlags[sisc_pkg::FLAG_RDY] = pins.rise[sisc_pkg::PIN_RDY] |
                                           pins.fall[sisc_pkg::PIN_RDY];
        end
        setFlags[sisc_pkg::FLAG_CD] = pins.rise[sisc_pkg::PIN_CD1] | pins.fall[sisc_pkg::PIN_CD1] |
                                      pins.rise[sisc_pkg::PIN_CD2] |
                                      pins.fall[sisc_pkg::PIN_CD2];

        // read clears, a new event in the same cycle still lands
        keptFlags = readFlags ? sisc_pkg::FLAGS_RESET : stQ.flags;
        stD.flags = keptFlags | setFlags;

        // register writes
        if (regWrite) begin
            if (regIndex == sisc_pkg::REG_CTRL_IDX) begin
                stD.ctrl = regWdata;
            end else if (regIndex == sisc_pkg::REG_MGMT_IDX) begin
                stD.mgmtEn = regWdata[sisc_pkg::NUM_FLAGS-1:0];
            end
        end

        // register reads, answered on the next edge
        stD.rvalid = regRead;
        if (regRead) begin
            if (regIndex == sisc_pkg::REG_CTRL_IDX) begin
                stD.rdata = stQ.ctrl;
            end else if (regIndex == sisc_pkg::REG_FLAGS_IDX) begin
                stD.rdata = {4'h0, stQ.flags};
            end else if (regIndex == sisc_pkg::REG_MGMT_IDX) begin
                stD.rdata = {4'h0, stQ.mgmtEn};
            end else begin
                stD.rdata = sisc_pkg::RDATA_RESET;
            end
        end

        // context cleared only when not retained
        if (clearCtx) begin
            stD.ctrl   = sisc_pkg::CTRL_RESET;
            stD.flags  = sisc_pkg::FLAGS_RESET;
            stD.mgmtEn = sisc_pkg::MGMT_RESET;
        end

        // management interrupt from enabled flags
        stD.mgmtIrq = |(stQ.flags & stQ.mgmtEn);

        // card irq: serial signalling, io mode, usable code, irq pin low
        stD.irqReq = serialIrqMode && ioMode && irqCodeUsable(irqSel, wayMode) &&
                     !pins.level[sisc_pkg::PIN_RDY];
        stD.irqLine = (serialIrqMode && ioMode) ? irqSel : sisc_pkg::IRQ_OFF;

        // dual-function pin use
        stD.ioMode = ioMode;

        // socket reset: active high normally, low in ata mode
        resetActive = !ataMode;
        stD.rstOut  = resetBit ? !resetActive : resetActive;
        stD.rstOe   = socketOutputEnable;

        // ring indicate passthrough, otherwise inactive high
        stD.powerEvent = (ringEn && ioMode) ? pins.level[sisc_pkg::PIN_BSR] : 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stQ.ctrl       <= sisc_pkg::CTRL_RESET;
            stQ.flags      <= sisc_pkg::FLAGS_RESET;
            stQ.mgmtEn     <= sisc_pkg::MGMT_RESET;
            stQ.rdata      <= sisc_pkg::RDATA_RESET;
            stQ.rvalid     <= 1'b0;
            stQ.irqReq     <= 1'b0;
            stQ.irqLine    <= sisc_pkg::IRQ_OFF;
            stQ.mgmtIrq    <= 1'b0;
            stQ.powerEvent <= 1'b1;
            stQ.rstOut     <= 1'b1;
            stQ.rstOe      <= 1'b0;
            stQ.ioMode     <= 1'b0;
        end else begin
            stQ <= stD;
        end
    end

    assign regRdata            = stQ.rdata;
    assign regRvalid           = stQ.rvalid;
    assign cardResetOut        = stQ.rstOut;
    assign cardResetOe         = stQ.rstOe;
    assign ioInterfaceMode     = stQ.ioMode;
    assign cardIrqReq          = stQ.irqReq;
    assign cardIrqLine         = stQ.irqLine;
    assign systemMgmtInterrupt = stQ.mgmtIrq;
    assign powerEventOutputN   = stQ.powerEvent;

endmodule : sisc_top

`default_nettype wire

// >>> rtl/sisc_pkg.sv
// socket interrupt/status control: constants, field layout, state types
// assumes a host-side indexed register port and a single host clock
package sisc_pkg;

    // register indices
    localparam logic [7:0] REG_CTRL_IDX  = 8'h03;
    localparam logic [7:0] REG_FLAGS_IDX = 8'h04;
    localparam logic [7:0] REG_MGMT_IDX  = 8'h05;

    // reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] MGMT_RESET  = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // control register fields
    localparam int CTRL_IRQ_LSB  = 0;
    localparam int CTRL_IRQ_MSB  = 3;
    localparam int CTRL_IO_BIT   = 5;
    localparam int CTRL_RST_BIT  = 6;
    localparam int CTRL_RING_BIT = 7;

    // change flag positions
    localparam int FLAG_BSR = 0;
    localparam int FLAG_BW  = 1;
    localparam int FLAG_RDY = 2;
    localparam int FLAG_CD  = 3;
    localparam int NUM_FLAGS = 4;

    // socket pin lanes in the synchroniser
    localparam int PIN_RDY = 0;
    localparam int PIN_BSR = 1;
    localparam int PIN_BW  = 2;
    localparam int PIN_CD1 = 3;
    localparam int PIN_CD2 = 4;
    localparam int NUM_PINS = 5;

    localparam logic [NUM_PINS-1:0] PIN_IDLE = 5'h1f;

    // card irq codes
    localparam logic [3:0] IRQ_OFF    = 4'h0;
    localparam logic [3:0] IRQ_WAY_1  = 4'h1;
    localparam logic [3:0] IRQ_WAY_2  = 4'h2;
    localparam logic [3:0] IRQ_WAY_6  = 4'h6;
    localparam logic [3:0] IRQ_WAY_8  = 4'h8;
    localparam logic [3:0] IRQ_WAY_13 = 4'hd;

    typedef struct packed {
        logic [NUM_PINS-1:0] meta;
        logic [NUM_PINS-1:0] sync;
        logic [NUM_PINS-1:0] prev;
    } sisc_sync_s;

    typedef struct packed {
        logic [7:0]           ctrl;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] mgmtEn;
        logic [7:0]           rdata;
        logic                 rvalid;
        logic                 irqReq;
        logic [3:0]           irqLine;
        logic                 mgmtIrq;
        logic                 powerEvent;
        logic                 rstOut;
        logic                 rstOe;
        logic                 ioMode;
    } sisc_top_s;

endpackage : sisc_pkg

// >>> rtl/sisc_pin_if.sv
// socket pin samples and edges between synchroniser and control core
// assumes both ends on the host clock
`timescale 1ns/100ps
`default_nettype none

interface sisc_pin_if;
    logic [sisc_pkg::NUM_PINS-1:0] level;
    logic [sisc_pkg::NUM_PINS-1:0] rise;
    logic [sisc_pkg::NUM_PINS-1:0] fall;

    modport sync (output level, output rise, output fall);
    modport user (input level, input rise, input fall);
endinterface : sisc_pin_if

`default_nettype wire

// >>> rtl/sisc_pin_sync.sv
// two-stage synchroniser and edge detector for the socket input pins
// assumes raw asynchronous pins, idle high
`timescale 1ns/100ps
`default_nettype none

module sisc_pin_sync (
    input  wire logic                          core_clk, // host clock
    input  wire logic                          rst_n,    // async reset, active low
    input  wire logic [sisc_pkg::NUM_PINS-1:0] pinRaw,   // raw socket pins
    sisc_pin_if.sync                           pins      // synced levels and edges
);

    sisc_pkg::sisc_sync_s stQ;
    sisc_pkg::sisc_sync_s stD;

    always_comb begin
        stD      = stQ;
        stD.meta = pinRaw;
        stD.sync = stQ.meta;
        stD.prev = stQ.sync;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stQ.meta <= sisc_pkg::PIN_IDLE;
            stQ.sync <= sisc_pkg::PIN_IDLE;
            stQ.prev <= sisc_pkg::PIN_IDLE;
        end else begin
            stQ <= stD;
        end
    end

    // edges compare current synced sample against the one before
    assign pins.level = stQ.sync;
    assign pins.rise  = stQ.sync & ~stQ.prev;
    assign pins.fall  = ~stQ.sync & stQ.prev;

endmodule : sisc_pin_sync

`default_nettype wire

// >>> tb/sisc_card_model.sv
// card model: drives the socket input pins, shows the reset wire
// assumes pins idle high until the bench commands a level
`timescale 1ns/100ps
`default_nettype none
module sisc_card_model (
    input  wire logic                          cardResetOut, // reset level
    input  wire logic                          cardResetOe,  // reset enable
    output logic [sisc_pkg::NUM_PINS-1:0]      pinLevel,     // pin lanes
    output wire logic                          resetSeen     // reset wire
);
    assign resetSeen = cardResetOe ? cardResetOut : 1'bz;
    initial pinLevel = sisc_pkg::PIN_IDLE;
    task automatic drive(input logic [sisc_pkg::NUM_PINS-1:0] v);
        pinLevel = v;
    endtask : drive
endmodule : sisc_card_model
`default_nettype wire

// >>> tb/sisc_checker_assertions.sv
// port checks for sisc_top
// assumes one host clock, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module sisc_checker (
    input wire logic       core_clk,             // clock
    input wire logic       rst_n,                // reset
    input wire logic [7:0] regIndex,             // index
    input wire logic       regWrite,             // write
    input wire logic       regRead,              // read
    input wire logic [7:0] regWdata,             // wdata
    input wire logic [7:0] regRdata,             // rdata
    input wire logic       regRvalid,            // valid
    input wire logic       softSegmentReset,     // soft reset
    input wire logic       serialIrqMode,        // serial
    input wire logic       ataMode,              // ata
    input wire logic       socketOutputEnable,   // enable
    input wire logic       cardReadyIrqPin,      // ready pin
    input wire logic       batteryStatusRingPin, // status pin
    input wire logic       cardResetOut,         // reset level
    input wire logic       cardResetOe,          // reset enable
    input wire logic       ioInterfaceMode,      // io mode
    input wire logic       cardIrqReq,           // irq
    input wire logic [3:0] cardIrqLine,          // irq code
    input wire logic       powerEventOutputN     // event
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ctrl_wr;
        regWrite && regIndex == sisc_pkg::REG_CTRL_IDX && !softSegmentReset ##1 1'b1;
    endsequence
    property p_rvalid; 1'b1 |=> regRvalid == $past(regRead); endproperty
    property p_high; regRead && regIndex == sisc_pkg::REG_FLAGS_IDX |=> regRdata[7:4] == 4'h0; endproperty
    property p_float; !socketOutputEnable |=> !cardResetOe; endproperty
    property p_level; s_ctrl_wr |=> cardResetOut == ($past(regWdata[6], 2) ^ !$past(ataMode)); endproperty
    property p_io; s_ctrl_wr |=> ioInterfaceMode == $past(regWdata[5], 2); endproperty
    property p_line; cardIrqLine != 4'h0 |-> ioInterfaceMode && $past(serialIrqMode); endproperty
    property p_req; cardIrqReq |-> !$past(cardReadyIrqPin, 3); endproperty
    property p_ring; !powerEventOutputN |-> ioInterfaceMode && !$past(batteryStatusRingPin, 3); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid mismatch");
    a_high: assert property (p_high) else $error("status upper bits set");
    a_float: assert property (p_float) else $error("reset driven while disabled");
    a_level: assert property (p_level) else $error("reset level wrong");
    a_io: assert property (p_io) else $error("io mode wrong");
    a_line: assert property (p_line) else $error("irq code outside serial io");
    a_req: assert property (p_req) else $error("irq without ready low");
    a_ring: assert property (p_ring) else $error("event without ring");
endmodule : sisc_checker
bind sisc_top sisc_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .regIndex(regIndex),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .softSegmentReset(softSegmentReset), .serialIrqMode(serialIrqMode),
    .ataMode(ataMode), .socketOutputEnable(socketOutputEnable), .cardReadyIrqPin(cardReadyIrqPin),
    .batteryStatusRingPin(batteryStatusRingPin), .cardResetOut(cardResetOut), .cardResetOe(cardResetOe),
    .ioInterfaceMode(ioInterfaceMode), .cardIrqReq(cardIrqReq), .cardIrqLine(cardIrqLine),
    .powerEventOutputN(powerEventOutputN));
`default_nettype wire

// >>> tb/sisc_top_bench.sv
// bench for sisc_top: registers, change flags, irq, reset pin
// assumes the card model on the socket pins
`timescale 1ns/100ps
`default_nettype none
module sisc_top_bench;
    logic       core_clk, rst_n, regWrite, regRead, softSegmentReset, powerContextRetained;
    logic       serialIrqMode, wayMode, ataMode, socketOutputEnable, regRvalid, cardResetOut;
    logic       cardResetOe, ioInterfaceMode, cardIrqReq, systemMgmtInterrupt, powerEventOutputN;
    logic [7:0] regIndex, regWdata, regRdata;
    logic [3:0] cardIrqLine;
    logic [4:0] pins;
    wire        resetSeen;
    int         failures = 0, check_count = 0, cycles = 0;
    // {ctrl, pins, expected flags}
    localparam logic [19:0] TV [14] = '{20'h001d1, 20'h001f0, 20'h001b2, 20'h001a4, 20'h00128,
        20'h00028, 20'h001fc, 20'h201d1, 20'h201f1, 20'h201a0, 20'ha0181, 20'ha01a1, 20'h20181, 20'h201f1};
    sisc_top uut (.core_clk(core_clk), .rst_n(rst_n), .regIndex(regIndex), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .softSegmentReset(softSegmentReset), .powerContextRetained(powerContextRetained),
        .serialIrqMode(serialIrqMode), .wayMode(wayMode), .ataMode(ataMode),
        .socketOutputEnable(socketOutputEnable), .cardReadyIrqPin(pins[0]), .batteryStatusRingPin(pins[1]),
        .batteryWarnSpeakerPin(pins[2]), .cardDetectOnePin(pins[3]), .cardDetectTwoPin(pins[4]),
        .cardResetOut(cardResetOut), .cardResetOe(cardResetOe), .ioInterfaceMode(ioInterfaceMode),
        .cardIrqReq(cardIrqReq), .cardIrqLine(cardIrqLine), .systemMgmtInterrupt(systemMgmtInterrupt),
        .powerEventOutputN(powerEventOutputN));
    sisc_card_model card (.cardResetOut(cardResetOut), .cardResetOe(cardResetOe), .pinLevel(pins),
        .resetSeen(resetSeen));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        regIndex = idx;
        regWdata = dat;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        regIndex = idx;
        regRead = 1'b1;
        tick(1);
        regRead = 1'b0;
        check("valid", {7'h0, regRvalid}, 8'h01);
        check(what, regRdata, exp);
        tick(1);
    endtask : rd
    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic t_regs;
        rd(8'h03, 8'h00, "ctrl reset");
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00, "flags");
        wr(8'h03, 8'hdf);
        rd(8'h03, 8'hdf, "ctrl");
        rd(8'h07, 8'h00, "unmapped");
    endtask : t_regs
    task automatic t_rstpin;
        socketOutputEnable = 1'b1;
        wr(8'h03, 8'h00);
        tick(2);
        check("reset", {7'h0, resetSeen}, 8'h01);
        ataMode = 1'b1;
        tick(2);
        check("reset", {7'h0, resetSeen}, 8'h00);
        wr(8'h03, 8'h40);
        tick(2);
        check("reset", {7'h0, resetSeen}, 8'h01);
        socketOutputEnable = 1'b0;
        tick(2);
        check("reset", {7'h0, resetSeen}, {7'h0, 1'bz});
        ataMode = 1'b0;
    endtask : t_rstpin
    task automatic t_pins;
        wr(8'h05, 8'h0e);
        for (int i = 0; i < 14; i++) begin
            wr(8'h03, TV[i][19:12]);
            card.drive(TV[i][8:4]);
            tick(5);
            check("mgmt", {7'h0, systemMgmtInterrupt}, {7'h0, |(TV[i][3:0] & 4'he)});
            check("event", {7'h0, powerEventOutputN}, {7'h0, !(TV[i][19] && TV[i][17] && !TV[i][5])});
            check("io", {7'h0, ioInterfaceMode}, {7'h0, TV[i][17]});
            rd(8'h04, {4'h0, TV[i][3:0]}, "flags");
            tick(1);
            check("mgmt", {7'h0, systemMgmtInterrupt}, 8'h00);
        end
    endtask : t_pins
    task automatic t_irq;
        logic [3:0] c;
        serialIrqMode = 1'b1;
        card.drive(5'h1e);
        for (int i = 0; i < 32; i++) begin
            c = i[3:0];
            wayMode = i[4];
            wr(8'h03, {4'h2, c});
            tick(4);
            check("line", {4'h0, cardIrqLine}, {4'h0, c});
            check("req", {7'h0, cardIrqReq}, {7'h0, c != 4'h0 && (i[4] || !(c inside {1, 2, 6, 8, 13}))});
        end
        card.drive(5'h1f);
        tick(4);
        check("idle req", {7'h0, cardIrqReq}, 8'h00);
        card.drive(5'h1e);
        tick(4);
        serialIrqMode = 1'b0;
        tick(2);
        check("pci", {3'h0, cardIrqReq, cardIrqLine}, 8'h00);
        serialIrqMode = 1'b1;
        wr(8'h03, 8'h03);
        tick(2);
        check("mem", {3'h0, cardIrqReq, cardIrqLine}, 8'h00);
        card.drive(5'h1f);
    endtask : t_irq
    task automatic t_keep;
        wr(8'h03, 8'h25);
        powerContextRetained = 1'b1;
        softSegmentReset = 1'b1;
        tick(1);
        softSegmentReset = 1'b0;
        rd(8'h03, 8'h25, "kept");
        powerContextRetained = 1'b0;
        softSegmentReset = 1'b1;
        tick(1);
        softSegmentReset = 1'b0;
        rd(8'h03, 8'h00, "cleared");
    endtask : t_keep
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {rst_n, regWrite, regRead, softSegmentReset, powerContextRetained} = 5'h00;
        {serialIrqMode, wayMode, ataMode, socketOutputEnable, regIndex, regWdata} = 20'h00000;
        repeat (2) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        t_regs();
        t_rstpin();
        t_pins();
        t_irq();
        t_keep();
        close_out();
    end
endmodule : sisc_top_bench
`default_nettype wire
